// >>> design/disk_port_defs.svh
// constants for the disk adapter register port
//
// How it works
// - five-bit select code decodes to one of eight registers
// - registers move on a two-way bus of sixteen data bits plus parity
// - gray counter steps the handshake table once per clock
// - handshake takes six clocks, uninterruptible, other port locked out
// - write latches bus into buffer, later strobe copies it to register
// - command write into control register sets go bit two clocks later
// - transfer acknowledge rises at the end of the timed sequence
// - acknowledge holds until demand drops, then falls
// - direction low with demand runs the read part of the table
// - read value loads the buffer and the bus drive in the same clock
// - seventeen-bit mux picks port A or port B bus
// - incoming data checked for odd parity; failure sets parity flag
// - attention summary puts own attention bit at unit number
// - holding register ignores direct writes; reads return its complement
// - every legal register write also loads the holding register
// - go accepts function; transfer commands wait for run line
// - maintenance register writes control half, reads monitor half
// - serial number register reads sixteen jumper inputs
// - look-ahead counter clears on index, counts sector pulses
// - disk address increments per transferred sector block
// - handshake starts only when unit select matches own address
// - write during command refused except to attention and holding, refused flag at error bit 2
`ifndef DISK_PORT_DEFS_SVH
`define DISK_PORT_DEFS_SVH
// ----------------------------------------
// register select codes
// ----------------------------------------
`define ADR_CTRL1 5'h00
`define ADR_ERR1 5'h02
`define ADR_MAINT1 5'h03
`define ADR_ATTN 5'h04
`define ADR_DADDR 5'h05
`define ADR_LOOK 5'h07
`define ADR_SERIAL 5'h0C
`define ADR_HOLD 5'h13
// ----------------------------------------
// fields and timing
// ----------------------------------------
`define ERR1_REFUSED_BIT 2
`define ERR1_PARITY_BIT 3
`define CTRL1_GO_BIT 0
`define XFER_FUNC_MIN 5'h14
`define HS_STEPS 6
`define HS_GRAY_LAST 3'h5
`define HS_LOAD_WR 3'h1
`define HS_STROBE_WR 3'h3
`define HS_LOAD_RD 3'h3
`endif

// >>> design/disk_port_pkg.sv
// types shared by the disk adapter register port
package disk_port_pkg;
	typedef enum logic [1:0] {HS_IDLE, HS_RUN, HS_ACK} hs_state_t;
	typedef logic [15:0] word_t;
endpackage : disk_port_pkg

// >>> design/sync_stage.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync_stage #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// pin side and clock side
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= pin_in;
			sync_out <= meta_reg;
		end
	end
endmodule : sync_stage
`default_nettype wire

// >>> design/handshake_seq.sv
// gray-coded handshake sequencer
`timescale 1ns/1ps
`default_nettype none
`include "disk_port_defs.svh"
module handshake_seq (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// control
	input wire logic start,
	input wire logic demand,
	input wire logic write_dir,
	// strobes and status
	output logic load_strobe,
	output logic write_strobe,
	output logic ack,
	output logic busy
);
	disk_port_pkg::hs_state_t state_reg, state_next;
	logic [2:0] gray_reg;
	logic [2:0] gray_next;

	// next gray code in the six-step table: 0,1,3,2,6,7,5 would be seven, so wrap at 5
	function automatic logic [2:0] gray_step(input logic [2:0] g);
		case (g)
			3'h0: gray_step = 3'h1;
			3'h1: gray_step = 3'h3;
			3'h3: gray_step = 3'h2;
			3'h2: gray_step = 3'h6;
			3'h6: gray_step = 3'h7;
			3'h7: gray_step = 3'h5;
			default: gray_step = 3'h0;
		endcase
	endfunction : gray_step

	assign gray_next = gray_step(gray_reg);
	assign busy = state_reg != disk_port_pkg::HS_IDLE;
	assign ack = state_reg == disk_port_pkg::HS_ACK;
	// read and write use different slots of the table
	assign load_strobe = state_reg == disk_port_pkg::HS_RUN &&
		gray_reg == (write_dir ? `HS_LOAD_WR : `HS_LOAD_RD);
	assign write_strobe = state_reg == disk_port_pkg::HS_RUN && write_dir &&
		gray_reg == `HS_STROBE_WR;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			disk_port_pkg::HS_IDLE: begin
				if (start) begin
					state_next = disk_port_pkg::HS_RUN;
				end
			end
			disk_port_pkg::HS_RUN: begin
				// no exit before the last step: the sequence cannot be cut short
				if (gray_next == `HS_GRAY_LAST) begin
					state_next = disk_port_pkg::HS_ACK;
				end
			end
			disk_port_pkg::HS_ACK: begin
				if (!demand) begin
					state_next = disk_port_pkg::HS_IDLE;
				end
			end
			default: state_next = disk_port_pkg::HS_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_reg <= disk_port_pkg::HS_IDLE;
			gray_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			gray_reg <= (state_reg == disk_port_pkg::HS_RUN) ? gray_next : 3'h0;
		end
	end
endmodule : handshake_seq
`default_nettype wire

// >>> design/disk_reg_port.sv
// register access port of the disk adapter
`timescale 1ns/1ps
`default_nettype none
`include "disk_port_defs.svh"
module disk_reg_port (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// port A control bus
	input wire logic [16:0] cbus_a_in,
	input wire logic demand_line_a,
	input wire logic controller_to_drive_dir_a,
	// port B control bus
	input wire logic [16:0] cbus_b_in,
	input wire logic demand_line_b,
	input wire logic controller_to_drive_dir_b,
	// shared selection lines
	input wire logic port_b_mode,
	input wire logic [4:0] register_select_lines,
	input wire logic [2:0] unit_select_lines,
	input wire logic [2:0] unit_address,
	// bus drive back to the controller
	output logic [16:0] cbus_out,
	output logic cbus_oe,
	output logic transfer_ack_line_a,
	output logic transfer_ack_line_b,
	// drive events
	input wire logic index_pulse,
	input wire logic sector_pulse,
	input wire logic sector_done,
	input wire logic attention_event,
	input wire logic run_line,
	input wire logic cmd_busy,
	input wire logic cmd_done,
	// static and monitor inputs
	input wire logic [15:0] serial_jumpers,
	input wire logic [15:0] maint_monitor,
	// control and status outputs
	output logic cmd_go,
	output logic cmd_exec,
	output logic [4:0] func_code,
	output logic [15:0] maint_control,
	output logic parity_error_flag,
	output logic refused_modification_flag,
	output logic attention_bit
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [16:0] bus_a_s, bus_b_s;
	logic [4:0] rs_s;
	logic [2:0] us_s, ua_s;
	logic [7:0] misc_s;
	logic dem_a_s, dem_b_s, dir_a_s, dir_b_s, port_b_s;
	logic idx_s, sec_s, run_s;

	sync_stage #(.WIDTH(34)) u_sync_bus (
		.sys_clk(sys_clk),
		.reset(reset),
		.pin_in({cbus_a_in, cbus_b_in}),
		.sync_out({bus_a_s, bus_b_s})
	);
	sync_stage #(.WIDTH(19)) u_sync_ctl (
		.sys_clk(sys_clk),
		.reset(reset),
		.pin_in({register_select_lines, unit_select_lines, unit_address,
			demand_line_a, demand_line_b, controller_to_drive_dir_a,
			controller_to_drive_dir_b, port_b_mode, index_pulse,
			sector_pulse, run_line}),
		.sync_out({rs_s, us_s, ua_s, misc_s})
	);
	assign {dem_a_s, dem_b_s, dir_a_s, dir_b_s, port_b_s, idx_s, sec_s, run_s} = misc_s;

	// ----------------------------------------
	// port arbitration and handshake
	// ----------------------------------------
	logic use_b_reg;
	logic hs_load, hs_write, hs_ack, hs_busy;
	wire unit_match = us_s == ua_s;
	wire dem_a_ok = dem_a_s && !port_b_s;
	wire dem_b_ok = dem_b_s && port_b_s;
	wire hs_start = !hs_busy && unit_match && (dem_a_ok || dem_b_ok);
	// the owning port is frozen while busy, so the other port is shut out
	wire use_b = hs_busy ? use_b_reg : dem_b_ok;
	wire act_dem = use_b ? dem_b_s : dem_a_s;
	wire act_dir = use_b ? dir_b_s : dir_a_s;
	wire [16:0] in_bus = use_b ? bus_b_s : bus_a_s;

	handshake_seq u_hs (
		.sys_clk(sys_clk),
		.reset(reset),
		.start(hs_start),
		.demand(act_dem),
		.write_dir(act_dir),
		.load_strobe(hs_load),
		.write_strobe(hs_write),
		.ack(hs_ack),
		.busy(hs_busy)
	);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	disk_port_pkg::word_t buf_reg, hold_reg, da_reg, err1_reg, maint_reg;
	logic [4:0] func_reg;
	logic go_reg, go_pend_reg, attn_reg;
	logic [5:0] look_reg;
	logic idx_d_reg, sec_d_reg;
	logic [16:0] out_reg;
	logic oe_reg, ack_a_reg, ack_b_reg;

	// odd parity over data plus parity bit
	function automatic logic odd_ok(input logic [16:0] v);
		odd_ok = ^v;
	endfunction : odd_ok

	wire adr_ctrl1 = rs_s == `ADR_CTRL1;
	wire adr_err1 = rs_s == `ADR_ERR1;
	wire adr_maint1 = rs_s == `ADR_MAINT1;
	wire adr_attn = rs_s == `ADR_ATTN;
	wire adr_daddr = rs_s == `ADR_DADDR;
	wire adr_look = rs_s == `ADR_LOOK;
	wire adr_serial = rs_s == `ADR_SERIAL;
	wire adr_hold = rs_s == `ADR_HOLD;
	wire adr_legal = adr_ctrl1 | adr_err1 | adr_maint1 | adr_attn | adr_daddr;
	wire [15:0] attn_word = 16'(attn_reg) << ua_s;

	// one shared read bus; anything unmapped returns the inverted holding word
	wire [15:0] rd_bus =
		adr_ctrl1 ? {10'h000, func_reg, go_reg} :
		adr_err1 ? err1_reg :
		adr_maint1 ? maint_monitor :
		adr_attn ? attn_word :
		adr_daddr ? da_reg :
		adr_look ? {10'h000, look_reg} :
		adr_serial ? serial_jumpers :
		~hold_reg;

	// attention and holding writes are allowed mid-command; others are refused
	wire wr_any = hs_write;
	wire wr_refused = wr_any && cmd_busy && !adr_attn && !adr_hold;
	wire wr_ok = wr_any && !wr_refused;
	wire par_bad = hs_load && act_dir && !odd_ok(in_bus);
	wire idx_edge = idx_s && !idx_d_reg;
	wire sec_edge = sec_s && !sec_d_reg;
	wire xfer_func = func_reg >= `XFER_FUNC_MIN;

	wire [15:0] err1_next_base = (wr_ok && adr_err1) ? buf_reg[15:0] : err1_reg;
	wire [15:0] err1_set = (16'(wr_refused) << `ERR1_REFUSED_BIT) |
		(16'(par_bad) << `ERR1_PARITY_BIT);

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			buf_reg <= 16'h0000;
			out_reg <= 17'h0_0000;
			oe_reg <= 1'b0;
			use_b_reg <= 1'b0;
		end else begin
			if (hs_start) begin
				use_b_reg <= dem_b_ok;
			end
			if (hs_load && act_dir) begin
				buf_reg <= in_bus[15:0];
			end
			if (hs_load && !act_dir) begin
				buf_reg <= rd_bus;
				out_reg <= {~^rd_bus, rd_bus};
				oe_reg <= 1'b1;
			end else if (!hs_busy) begin
				oe_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			hold_reg <= 16'h0000;
			func_reg <= 5'h00;
			go_pend_reg <= 1'b0;
			go_reg <= 1'b0;
			maint_reg <= 16'h0000;
			err1_reg <= 16'h0000;
			attn_reg <= 1'b0;
		end else begin
			if (wr_ok && adr_legal) begin
				hold_reg <= buf_reg;
			end
			go_pend_reg <= wr_ok && adr_ctrl1 && buf_reg[`CTRL1_GO_BIT];
			if (wr_ok && adr_ctrl1) begin
				func_reg <= buf_reg[5:1];
			end
			if (go_pend_reg) begin
				go_reg <= 1'b1;
			end else if (cmd_done) begin
				go_reg <= 1'b0;
			end
			if (wr_ok && adr_maint1) begin
				maint_reg <= buf_reg;
			end
			err1_reg <= err1_next_base | err1_set;
			if (attention_event) begin
				attn_reg <= 1'b1;
			end else if (wr_ok && adr_attn && buf_reg[ua_s]) begin
				attn_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// sector counters
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			look_reg <= 6'h00;
			da_reg <= 16'h0000;
			idx_d_reg <= 1'b0;
			sec_d_reg <= 1'b0;
		end else begin
			idx_d_reg <= idx_s;
			sec_d_reg <= sec_s;
			if (idx_edge) begin
				look_reg <= 6'h00;
			end else if (sec_edge) begin
				look_reg <= look_reg + 6'h01;
			end
			if (wr_ok && adr_daddr) begin
				da_reg <= buf_reg;
			end else if (sector_done) begin
				da_reg <= da_reg + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// output flops
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ack_a_reg <= 1'b0;
			ack_b_reg <= 1'b0;
			cmd_exec <= 1'b0;
		end else begin
			ack_a_reg <= hs_ack && !use_b;
			ack_b_reg <= hs_ack && use_b;
			cmd_exec <= go_reg && (!xfer_func || run_s);
		end
	end

	assign cbus_out = out_reg;
	assign cbus_oe = oe_reg;
	assign transfer_ack_line_a = ack_a_reg;
	assign transfer_ack_line_b = ack_b_reg;
	assign cmd_go = go_reg;
	assign func_code = func_reg;
	assign maint_control = maint_reg;
	assign parity_error_flag = err1_reg[`ERR1_PARITY_BIT];
	assign refused_modification_flag = err1_reg[`ERR1_REFUSED_BIT];
	assign attention_bit = attn_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	chk_go_after_write: assert property (
		wr_ok && adr_ctrl1 && buf_reg[0] |-> ##2 go_reg)
		else $error("go bit not set after command write");
	chk_hs_length: assert property (
		$rose(hs_busy) |-> !hs_ack [*6] ##1 hs_ack)
		else $error("handshake not six cycles");
	chk_ack_holds: assert property (
		hs_ack && act_dem |=> hs_ack)
		else $error("acknowledge dropped while demand held");
	chk_ack_drops: assert property (
		hs_ack && !act_dem |=> !hs_busy ##1 !(ack_a_reg || ack_b_reg))
		else $error("acknowledge stuck after demand drop");
	chk_port_locked: assert property (
		hs_busy && $past(hs_busy) |-> use_b == $past(use_b))
		else $error("port changed during handshake");
	chk_hold_mirror: assert property (
		wr_ok && adr_legal |=> hold_reg == $past(buf_reg))
		else $error("holding register not loaded");
	chk_hold_direct: assert property (
		wr_ok && adr_hold |=> hold_reg == $past(hold_reg))
		else $error("holding register changed by direct write");
	chk_refused_flag: assert property (
		wr_refused |=> refused_modification_flag)
		else $error("refused write not flagged");
	chk_parity_flag: assert property (
		par_bad |=> parity_error_flag)
		else $error("parity error not flagged");
	chk_look_clear: assert property (
		idx_edge |=> look_reg == 6'h00)
		else $error("look-ahead not cleared on index");
	chk_unit_match: assert property (
		hs_start |-> us_s == ua_s)
		else $error("handshake began for another unit");
	chk_read_drive: assert property (
		hs_load && !act_dir |=> cbus_oe && cbus_out[15:0] == $past(rd_bus))
		else $error("read value not driven");
endmodule : disk_reg_port
`default_nettype wire

// >>> tb/ctl_model.sv
// controller-side model of one control bus port
`timescale 1ns/1ps
`default_nettype none
module ctl_model (
	// clock
	input wire logic sys_clk,
	// toward the adapter
	output logic [16:0] cbus,
	output logic demand,
	output logic dir,
	// from the adapter
	input wire logic ack,
	input wire logic [16:0] rd_bus
);
	initial begin
		cbus = 17'h1_5555;
		demand = 1'h0;
		dir = 1'h0;
	end
	// one access; bad flips parity, ok stays low if the answer never comes
	task automatic xfer(input logic wr, input logic [15:0] d, input logic bad,
		output logic [16:0] q, output logic ok);
		int n;
		@(posedge sys_clk);
		#1;
		cbus = {~^d ^ bad, d};
		dir = wr;
		@(posedge sys_clk);
		#1;
		demand = 1'h1;
		n = 0;
		ok = 1'h0;
		q = 17'h0_0000;
		while (n < 40 && !ok) begin
			@(posedge sys_clk);
			ok = (ack === 1'h1);
			q = rd_bus;
			n++;
		end
		#1;
		demand = 1'h0;
		n = 0;
		while (n < 40 && ack !== 1'h0) begin
			@(posedge sys_clk);
			n++;
		end
		ok = ok && (ack === 1'h0);
		#1;
		// released lines must not keep the old value
		cbus = ~cbus;
	endtask : xfer
endmodule : ctl_model
`default_nettype wire

// >>> tb/disk_adapter_register_port_tb_top.sv
// self-checking bench for the disk adapter register port
`timescale 1ns/1ps
`default_nettype none
`include "disk_port_defs.svh"
module disk_adapter_register_port_tb_top;
	logic sys_clk = 1'h0;
	logic reset = 1'h1;
	logic port_b_mode = 1'h0;
	logic [4:0] rsel = 5'h00;
	logic [2:0] usel = 3'h0;
	logic [2:0] uaddr = 3'h0;
	logic index_pulse = 1'h0;
	logic sector_pulse = 1'h0;
	logic sector_done = 1'h0;
	logic attention_event = 1'h0;
	logic run_line = 1'h0;
	logic cmd_busy = 1'h0;
	logic cmd_done = 1'h0;
	logic [15:0] jumpers = 16'h0000;
	logic [15:0] monitor = 16'h0000;
	wire logic [16:0] cbus_a, cbus_b, cbus_out;
	wire logic dem_a, dem_b, dir_a, dir_b, ack_a, ack_b, cbus_oe;
	wire logic cmd_go, cmd_exec, par_flag, ref_flag, attention_bit;
	wire logic [4:0] func_code;
	wire logic [15:0] maint_control;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cycles = 0;
	integer seed;
	logic [15:0] hold_m, v, v2, d;
	logic [16:0] q, q2;
	logic ok, ok2;
	logic oe_at_ack = 1'h0;
	logic [4:0] fn [2] = '{5'h05, 5'h18};

	always #12.5 sys_clk = ~sys_clk;

	// bus drive as it stands while acknowledge is up
	always @(posedge sys_clk) begin
		if (ack_a || ack_b) begin
			oe_at_ack <= cbus_oe;
		end
	end

	ctl_model ctl_a (.sys_clk(sys_clk), .cbus(cbus_a), .demand(dem_a), .dir(dir_a),
		.ack(ack_a), .rd_bus(cbus_out));
	ctl_model ctl_b (.sys_clk(sys_clk), .cbus(cbus_b), .demand(dem_b), .dir(dir_b),
		.ack(ack_b), .rd_bus(cbus_out));

	disk_reg_port dut (.sys_clk(sys_clk), .reset(reset),
		.cbus_a_in(cbus_a), .demand_line_a(dem_a), .controller_to_drive_dir_a(dir_a),
		.cbus_b_in(cbus_b), .demand_line_b(dem_b), .controller_to_drive_dir_b(dir_b),
		.port_b_mode(port_b_mode), .register_select_lines(rsel),
		.unit_select_lines(usel), .unit_address(uaddr),
		.cbus_out(cbus_out), .cbus_oe(cbus_oe),
		.transfer_ack_line_a(ack_a), .transfer_ack_line_b(ack_b),
		.index_pulse(index_pulse), .sector_pulse(sector_pulse), .sector_done(sector_done),
		.attention_event(attention_event), .run_line(run_line), .cmd_busy(cmd_busy),
		.cmd_done(cmd_done), .serial_jumpers(jumpers), .maint_monitor(monitor),
		.cmd_go(cmd_go), .cmd_exec(cmd_exec), .func_code(func_code),
		.maint_control(maint_control), .parity_error_flag(par_flag),
		.refused_modification_flag(ref_flag), .attention_bit(attention_bit));

	task automatic results();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results

	// a hung handshake must not stall the run
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 4000) begin
			n_mismatch++;
			results();
		end
	end

	task automatic check(input string w, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", w, e, s);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick

	task automatic acc(input logic [4:0] a, input logic wr, input logic [15:0] x,
		input logic bad);
		tick(1);
		rsel = a;
		if (port_b_mode) begin
			ctl_b.xfer(wr, x, bad, q, ok);
		end else begin
			ctl_a.xfer(wr, x, bad, q, ok);
		end
		tick(1);
	endtask : acc

	task automatic wrt(input logic [4:0] a, input logic [15:0] x);
		acc(a, 1'h1, x, 1'h0);
		check("write ack", ok, 1);
		check("write oe", oe_at_ack, 0);
		hold_m = x;
	endtask : wrt

	task automatic rdc(input logic [4:0] a, input string w, input logic [15:0] e);
		acc(a, 1'h0, 16'h0000, 1'h0);
		check("read ack", ok, 1);
		check(w, q[15:0], e);
		check("read parity", ^q, 1);
		check("read oe", oe_at_ack, 1);
		check("oe release", cbus_oe, 0);
	endtask : rdc

	task automatic pulse(input logic idx);
		if (idx) index_pulse = 1'h1;
		else sector_pulse = 1'h1;
		tick(3);
		index_pulse = 1'h0;
		sector_pulse = 1'h0;
		tick(3);
	endtask : pulse

	initial begin
		seed = 1;
		uaddr = 3'($random(seed));
		usel = uaddr;
		jumpers = 16'($random(seed));
		monitor = 16'($random(seed));
		tick(10);
		reset = 1'h0;
		tick(3);
		v = 16'($random(seed));
		wrt(`ADR_MAINT1, v);
		check("maint", maint_control, v);
		rdc(`ADR_HOLD, "hold", ~hold_m);
		wrt(`ADR_HOLD, ~v);
		hold_m = v;
		rdc(`ADR_HOLD, "hold kept", ~hold_m);
		rdc(5'h1f, "unmapped", ~hold_m);
		rdc(`ADR_MAINT1, "monitor", monitor);
		rdc(`ADR_SERIAL, "serial", jumpers);
		foreach (fn[i]) begin
			wrt(`ADR_CTRL1, {10'h000, fn[i], 1'h1});
			check("go", cmd_go, 1);
			check("func", func_code, fn[i]);
			tick(4);
			check("exec", cmd_exec, fn[i] < `XFER_FUNC_MIN);
			run_line = 1'h1;
			tick(5);
			check("exec run", cmd_exec, 1);
			run_line = 1'h0;
			cmd_done = 1'h1;
			tick(1);
			cmd_done = 1'h0;
			tick(2);
			check("go done", cmd_go, 0);
		end
		pulse(1);
		repeat (3) pulse(0);
		rdc(`ADR_LOOK, "look", 16'h0003);
		pulse(1);
		rdc(`ADR_LOOK, "look clr", 16'h0000);
		d = 16'($random(seed)) & 16'h0ff0;
		wrt(`ADR_DADDR, d);
		repeat (2) begin
			sector_done = 1'h1;
			tick(1);
			sector_done = 1'h0;
			tick(1);
		end
		rdc(`ADR_DADDR, "daddr", d + 16'h0002);
		attention_event = 1'h1;
		tick(1);
		attention_event = 1'h0;
		tick(2);
		check("attn", attention_bit, 1);
		rdc(`ADR_ATTN, "attn sum", 16'h0001 << uaddr);
		wrt(`ADR_ATTN, 16'h0001 << uaddr);
		check("attn clr", attention_bit, 0);
		usel = uaddr + 3'h1;
		acc(`ADR_MAINT1, 1'h1, ~v, 1'h0);
		check("unit ack", ok, 0);
		check("unit maint", maint_control, v);
		usel = uaddr;
		port_b_mode = 1'h1;
		tick(3);
		v2 = 16'($random(seed));
		wrt(`ADR_MAINT1, v2);
		check("port b", maint_control, v2);
		rdc(`ADR_HOLD, "hold b", ~v2);
		port_b_mode = 1'h0;
		tick(3);
		cmd_busy = 1'h1;
		acc(`ADR_MAINT1, 1'h1, ~v2, 1'h0);
		cmd_busy = 1'h0;
		check("refused", maint_control, v2);
		check("ref flag", ref_flag, 1);
		acc(`ADR_MAINT1, 1'h1, v, 1'h1);
		check("par flag", par_flag, 1);
		wrt(`ADR_ERR1, 16'h0000);
		check("par clr", par_flag, 0);
		check("ref clr", ref_flag, 0);
		// port B demands from a cycle before port A and is shut out by port A mode
		v2 = ~v;
		fork
			acc(`ADR_MAINT1, 1'h1, v2, 1'h0);
			ctl_b.xfer(1'h1, v, 1'h0, q2, ok2);
		join
		check("port a ack", ok, 1);
		check("port b shut", ok2, 0);
		check("port a maint", maint_control, v2);
		results();
	end
endmodule : disk_adapter_register_port_tb_top
`default_nettype wire
